//--- verilog/opsm_defs.vh
// register map, field positions and reset values of the output port block
// assumes a 32-bit ahb-lite slave decoding byte addresses in the low bits
`ifndef OPSM_DEFS_VH
`define OPSM_DEFS_VH

// word-aligned byte offsets
`define OPSM_OFF_DATA   4'h0
`define OPSM_OFF_HIZ    4'h4
`define OPSM_OFF_CTRL   4'h8
`define OPSM_OFF_STAT   4'hc
`define OPSM_ADDR_MSB   3

// dedicated pin indices inside the data and hiz words
`define OPSM_P_INVT     0
`define OPSM_P_TCLK     1
`define OPSM_P_OSC      2
`define OPSM_P_BUZ      3
`define OPSM_P_INVB     4
`define OPSM_PIN_MSB    4
`define OPSM_SEG_LSB    16
`define OPSM_SEG_MSB    26

// control word fields
`define OPSM_C_TCLK_ON  0
`define OPSM_C_OSC_ON   1
`define OPSM_C_DIV_LSB  2
`define OPSM_C_DIV_MSB  4
`define OPSM_C_BUZ_ON   5
`define OPSM_C_BUZ_SHOT 6
`define OPSM_C_HSO      8

// status word fields
`define OPSM_S_TCLK     0
`define OPSM_S_OSC      1
`define OPSM_S_BUZ      2
`define OPSM_S_STOP     3
`define OPSM_S_LVL_LSB  4
`define OPSM_S_LVL_MSB  8
`define OPSM_S_OE_LSB   12
`define OPSM_S_OE_MSB   16

// reset values
`define OPSM_PIN_RST    5'h00
`define OPSM_SEG_RST    11'h000
`define OPSM_DIV_RST    3'h0
`define OPSM_HSO_RST    1'b1

// build-time choices for the inverted timer or carrier pin
`define OPSM_INVT_DC    2'h0
`define OPSM_INVT_TIMER 2'h1
`define OPSM_INVT_CARR  2'h2

`endif

//--- verilog/opsm_clk_div.v
// divider for the oscillator clock output: ratio 1, 2, 4 or 8
// assumes src_in is a level sampled synchronously to hclk
`timescale 1ns/1ps

module opsm_clk_div (
	// clock and reset
	input  wire       hclk,
	input  wire       hresetn,
	// source and ratio (0..3 -> /1 /2 /4 /8)
	input  wire       src_in,
	input  wire [1:0] ratio,
	// divided level
	output reg        div_out
);

	reg       src_d_r;
	reg [2:0] cnt_r;
	wire [2:0] cnt_nxt;
	reg       div_nxt;

	// each counter bit toggles at half the rate of the one below
	assign cnt_nxt = (src_in && !src_d_r) ? cnt_r + 3'h1 : cnt_r;

	always @* begin
		case (ratio)
			2'h0:    div_nxt = src_in;
			2'h1:    div_nxt = cnt_r[0];
			2'h2:    div_nxt = cnt_r[1];
			2'h3:    div_nxt = cnt_r[2];
			default: div_nxt = 1'b0;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			src_d_r <= 1'b0;
			cnt_r   <= 3'h0;
			div_out <= 1'b0;
		end else begin
			src_d_r <= src_in;
			cnt_r   <= cnt_nxt;
			div_out <= div_nxt;
		end
	end

endmodule

//--- verilog/opsm_top.v
// output port block: five dedicated pins, eleven segment pins, special sources
// assumes one ahb-lite master, all source signals synchronous to hclk
//
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "opsm_defs.vh"

// Function
// - every pin drives push-pull whenever it is not floated
// - hiz select 1 floats the pin, 0 drives it
// - in dc mode data 1 drives high, data 0 drives low
// - data written while floated is kept and shows on release
// - segment hiz bits act only in dc mode, else plain storage
// - three pins chosen by software, two inverted pins by build option
// - carrier option cuts the inverted timer pin data from the pin
// - timer output on: clock anded with data, and inverse; off: pin follows its data bit, inverse pin low
// - timer clock toggles on each underflow, half the underflow rate
// - osc output on drives divided clock anded with data, off drives its data bit
// - 3-bit select: low or high oscillator divided by 1, 2, 4, 8
// - high-speed oscillator runs after reset
// - buzzer on or one-shot ors buzzer into data; off or stop: pin follows its data bit, inverse high
// - gating is unsynchronised to enables; short glitches accepted
// - all hiz select bits reset to 0
module opsm_top #(
	parameter [1:0]  INV_TIMER_MODE  = `OPSM_INVT_DC,
	parameter        INV_BUZZER_MODE = 0,
	parameter [10:0] SEG_DC_MASK     = 11'h000
) (
	// ahb-lite slave
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	// special sources
	input  wire        timer_underflow,
	input  wire        buzzer_signal,
	input  wire        ir_carrier_signal,
	input  wire        low_speed_oscillator,
	input  wire        high_speed_oscillator,
	input  wire        buzzer_one_shot_stop,
	input  wire [10:0] seg_lcd_level,
	output wire        high_speed_osc_run,
	// dedicated pins
	output reg         inv_timer_or_carrier_pin_o,
	output reg         inv_timer_or_carrier_pin_oe,
	output reg         timer_clock_pin_o,
	output reg         timer_clock_pin_oe,
	output reg         osc_clock_pin_o,
	output reg         osc_clock_pin_oe,
	output reg         buzzer_pin_o,
	output reg         buzzer_pin_oe,
	output reg         inv_buzzer_pin_o,
	output reg         inv_buzzer_pin_oe,
	// segment pins
	output reg  [10:0] segment_dc_pins_o,
	output reg  [10:0] segment_dc_pins_oe
);

	// ----------------------------------------------------------------
	// register decode helpers
	// ----------------------------------------------------------------

	function is_reg;
		input [`OPSM_ADDR_MSB:0] addr;
		input [`OPSM_ADDR_MSB:0] off;
		begin
			is_reg = (addr == off);
		end
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------

	reg  [`OPSM_PIN_MSB:0]     pin_data_r;
	reg  [`OPSM_PIN_MSB:0]     pin_data_nxt;
	reg  [`OPSM_PIN_MSB:0]     pin_hiz_r;
	reg  [`OPSM_PIN_MSB:0]     pin_hiz_nxt;
	reg  [10:0]                seg_data_r;
	reg  [10:0]                seg_data_nxt;
	reg  [10:0]                seg_hiz_r;
	reg  [10:0]                seg_hiz_nxt;
	reg                        tclk_on_r;
	reg                        tclk_on_nxt;
	reg                        osc_on_r;
	reg                        osc_on_nxt;
	reg  [2:0]                 div_sel_r;
	reg  [2:0]                 div_sel_nxt;
	reg                        buz_on_r;
	reg                        buz_on_nxt;
	reg                        buz_shot_r;
	reg                        buz_shot_nxt;
	reg                        hso_on_r;
	reg                        hso_on_nxt;
	reg                        timer_clock_signal_r;
	reg                        dp_valid_r;
	reg                        dp_write_r;
	reg  [`OPSM_ADDR_MSB:0]    dp_addr_r;
	reg  [31:0]                rdata_nxt;
	wire                       ap_take;
	wire [`OPSM_ADDR_MSB:0]    ap_addr;
	wire                       divided_osc_signal;
	wire                       osc_src;
	wire                       buz_gate;
	reg  [`OPSM_PIN_MSB:0]     lvl_nxt;
	reg  [`OPSM_PIN_MSB:0]     oe_nxt;
	wire [10:0]                seg_lvl_nxt;
	wire [10:0]                seg_oe_nxt;

	// ----------------------------------------------------------------
	// ahb-lite slave: zero wait states, always okay
	// ----------------------------------------------------------------

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign ap_take   = hsel && hready && htrans[1];
	assign ap_addr   = haddr[`OPSM_ADDR_MSB:0];

	// hsize is not decoded: only whole-word transfers are supported
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid_r <= 1'b0;
			dp_write_r <= 1'b0;
			dp_addr_r  <= 4'h0;
		end else if (hready) begin
			dp_valid_r <= ap_take;
			dp_write_r <= hwrite;
			dp_addr_r  <= ap_addr;
		end
	end

	// ----------------------------------------------------------------
	// register writes in the data phase
	// ----------------------------------------------------------------

	always @* begin
		pin_data_nxt = pin_data_r;
		pin_hiz_nxt  = pin_hiz_r;
		seg_data_nxt = seg_data_r;
		seg_hiz_nxt  = seg_hiz_r;
		tclk_on_nxt  = tclk_on_r;
		osc_on_nxt   = osc_on_r;
		div_sel_nxt  = div_sel_r;
		buz_on_nxt   = buz_on_r;
		buz_shot_nxt = buz_shot_r;
		hso_on_nxt   = hso_on_r;
		if (dp_valid_r && dp_write_r) begin
			// data is stored regardless of hiz, so it appears on release
			if (is_reg(dp_addr_r, `OPSM_OFF_DATA)) begin
				pin_data_nxt = hwdata[`OPSM_PIN_MSB:0];
				seg_data_nxt = hwdata[`OPSM_SEG_MSB:`OPSM_SEG_LSB];
			end
			if (is_reg(dp_addr_r, `OPSM_OFF_HIZ)) begin
				pin_hiz_nxt = hwdata[`OPSM_PIN_MSB:0];
				seg_hiz_nxt = hwdata[`OPSM_SEG_MSB:`OPSM_SEG_LSB];
			end
			if (is_reg(dp_addr_r, `OPSM_OFF_CTRL)) begin
				tclk_on_nxt  = hwdata[`OPSM_C_TCLK_ON];
				osc_on_nxt   = hwdata[`OPSM_C_OSC_ON];
				div_sel_nxt  = hwdata[`OPSM_C_DIV_MSB:`OPSM_C_DIV_LSB];
				buz_on_nxt   = hwdata[`OPSM_C_BUZ_ON];
				buz_shot_nxt = hwdata[`OPSM_C_BUZ_SHOT];
				hso_on_nxt  = hwdata[`OPSM_C_HSO];
			end
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_data_r <= `OPSM_PIN_RST;
			pin_hiz_r  <= `OPSM_PIN_RST;
			seg_data_r <= `OPSM_SEG_RST;
			seg_hiz_r  <= `OPSM_SEG_RST;
			tclk_on_r  <= 1'b0;
			osc_on_r   <= 1'b0;
			div_sel_r  <= `OPSM_DIV_RST;
			buz_on_r   <= 1'b0;
			buz_shot_r <= 1'b0;
			hso_on_r   <= `OPSM_HSO_RST;
		end else begin
			pin_data_r <= pin_data_nxt;
			pin_hiz_r  <= pin_hiz_nxt;
			seg_data_r <= seg_data_nxt;
			seg_hiz_r  <= seg_hiz_nxt;
			tclk_on_r  <= tclk_on_nxt;
			osc_on_r   <= osc_on_nxt;
			div_sel_r  <= div_sel_nxt;
			buz_on_r   <= buz_on_nxt;
			buz_shot_r <= buz_shot_nxt;
			hso_on_r   <= hso_on_nxt;
		end
	end

	// the oscillator itself lives elsewhere; this only drives its run request
	assign high_speed_osc_run = hso_on_r;

	// ----------------------------------------------------------------
	// register reads, captured at the address phase
	// ----------------------------------------------------------------

	// reading the next values forwards a write in the preceding data phase
	always @* begin
		rdata_nxt = 32'h0000_0000;
		if (is_reg(ap_addr, `OPSM_OFF_DATA)) begin
			rdata_nxt[`OPSM_PIN_MSB:0]             = pin_data_nxt;
			rdata_nxt[`OPSM_SEG_MSB:`OPSM_SEG_LSB] = seg_data_nxt;
		end
		if (is_reg(ap_addr, `OPSM_OFF_HIZ)) begin
			rdata_nxt[`OPSM_PIN_MSB:0]             = pin_hiz_nxt;
			rdata_nxt[`OPSM_SEG_MSB:`OPSM_SEG_LSB] = seg_hiz_nxt;
		end
		if (is_reg(ap_addr, `OPSM_OFF_CTRL)) begin
			rdata_nxt[`OPSM_C_TCLK_ON]               = tclk_on_nxt;
			rdata_nxt[`OPSM_C_OSC_ON]                = osc_on_nxt;
			rdata_nxt[`OPSM_C_DIV_MSB:`OPSM_C_DIV_LSB] = div_sel_nxt;
			rdata_nxt[`OPSM_C_BUZ_ON]                = buz_on_nxt;
			rdata_nxt[`OPSM_C_BUZ_SHOT]              = buz_shot_nxt;
			rdata_nxt[`OPSM_C_HSO]                   = hso_on_nxt;
		end
		if (is_reg(ap_addr, `OPSM_OFF_STAT)) begin
			rdata_nxt[`OPSM_S_TCLK]                    = timer_clock_signal_r;
			rdata_nxt[`OPSM_S_OSC]                     = divided_osc_signal;
			rdata_nxt[`OPSM_S_BUZ]                     = buzzer_signal;
			rdata_nxt[`OPSM_S_STOP]                    = buzzer_one_shot_stop;
			rdata_nxt[`OPSM_S_LVL_MSB:`OPSM_S_LVL_LSB] = {inv_buzzer_pin_o, buzzer_pin_o,
				osc_clock_pin_o, timer_clock_pin_o, inv_timer_or_carrier_pin_o};
			rdata_nxt[`OPSM_S_OE_MSB:`OPSM_S_OE_LSB]   = {inv_buzzer_pin_oe, buzzer_pin_oe,
				osc_clock_pin_oe, timer_clock_pin_oe, inv_timer_or_carrier_pin_oe};
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (ap_take && !hwrite) begin
			hrdata <= rdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// special sources
	// ----------------------------------------------------------------

	// halving the underflow rate gives a clean 50 percent duty clock
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer_clock_signal_r <= 1'b0;
		end else if (timer_underflow) begin
			timer_clock_signal_r <= !timer_clock_signal_r;
		end
	end

	// bit 2 picks the oscillator, bits 1:0 the ratio
	assign osc_src = div_sel_r[2] ? high_speed_oscillator : low_speed_oscillator;

	opsm_clk_div u_div (
		.hclk    (hclk),
		.hresetn (hresetn),
		.src_in  (osc_src),
		.ratio   (div_sel_r[1:0]),
		.div_out (divided_osc_signal)
	);

	// stop wins over both starts
	assign buz_gate = (buz_on_r || buz_shot_r) && !buzzer_one_shot_stop;

	// ----------------------------------------------------------------
	// dedicated pin muxing
	// ----------------------------------------------------------------

	// enables are not aligned to source edges, so a short pulse may appear
	always @* begin
		oe_nxt = ~pin_hiz_r;
		// inverted timer pin: fixed by build option
		case (INV_TIMER_MODE)
			`OPSM_INVT_TIMER: lvl_nxt[`OPSM_P_INVT] = tclk_on_r && !timer_clock_signal_r;
			`OPSM_INVT_CARR:  lvl_nxt[`OPSM_P_INVT] = ir_carrier_signal;
			default:          lvl_nxt[`OPSM_P_INVT] = pin_data_r[`OPSM_P_INVT];
		endcase
		// data is anded in, so it must be held at 1 while clocking
		lvl_nxt[`OPSM_P_TCLK] = pin_data_r[`OPSM_P_TCLK] &&
			(!tclk_on_r || timer_clock_signal_r);
		lvl_nxt[`OPSM_P_OSC] = pin_data_r[`OPSM_P_OSC] &&
			(!osc_on_r || divided_osc_signal);
		// data is ored in, so it must be held at 0 while sounding
		lvl_nxt[`OPSM_P_BUZ] = pin_data_r[`OPSM_P_BUZ] ||
			(buz_gate && buzzer_signal);
		if (INV_BUZZER_MODE != 0) begin
			lvl_nxt[`OPSM_P_INVB] = !(buz_gate && buzzer_signal);
		end else begin
			lvl_nxt[`OPSM_P_INVB] = pin_data_r[`OPSM_P_INVB];
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			inv_timer_or_carrier_pin_o  <= 1'b0;
			inv_timer_or_carrier_pin_oe <= 1'b0;
			timer_clock_pin_o           <= 1'b0;
			timer_clock_pin_oe          <= 1'b0;
			osc_clock_pin_o             <= 1'b0;
			osc_clock_pin_oe            <= 1'b0;
			buzzer_pin_o                <= 1'b0;
			buzzer_pin_oe               <= 1'b0;
			inv_buzzer_pin_o            <= 1'b0;
			inv_buzzer_pin_oe           <= 1'b0;
		end else begin
			inv_timer_or_carrier_pin_o  <= lvl_nxt[`OPSM_P_INVT];
			inv_timer_or_carrier_pin_oe <= oe_nxt[`OPSM_P_INVT];
			timer_clock_pin_o           <= lvl_nxt[`OPSM_P_TCLK];
			timer_clock_pin_oe          <= oe_nxt[`OPSM_P_TCLK];
			osc_clock_pin_o             <= lvl_nxt[`OPSM_P_OSC];
			osc_clock_pin_oe            <= oe_nxt[`OPSM_P_OSC];
			buzzer_pin_o                <= lvl_nxt[`OPSM_P_BUZ];
			buzzer_pin_oe               <= oe_nxt[`OPSM_P_BUZ];
			inv_buzzer_pin_o            <= lvl_nxt[`OPSM_P_INVB];
			inv_buzzer_pin_oe           <= oe_nxt[`OPSM_P_INVB];
		end
	end

	// ----------------------------------------------------------------
	// segment pins
	// ----------------------------------------------------------------

	// a segment left to the lcd driver always drives its lcd level
	genvar gi;
	generate
		for (gi = 0; gi < 11; gi = gi + 1) begin : g_seg
			if (SEG_DC_MASK[gi]) begin : g_dc
				assign seg_lvl_nxt[gi] = seg_data_r[gi];
				assign seg_oe_nxt[gi]  = !seg_hiz_r[gi];
			end else begin : g_lcd
				assign seg_lvl_nxt[gi] = seg_lcd_level[gi];
				assign seg_oe_nxt[gi]  = 1'b1;
			end
		end
	endgenerate

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			segment_dc_pins_o  <= `OPSM_SEG_RST;
			segment_dc_pins_oe <= `OPSM_SEG_RST;
		end else begin
			segment_dc_pins_o  <= seg_lvl_nxt;
			segment_dc_pins_oe <= seg_oe_nxt;
		end
	end

endmodule

//--- bench/opsm_top_monitor.sv
// bus-side and pin-side checks of the output port block
// assumes hready tied to hreadyout and one master issuing word transfers
`timescale 1ns/1ps

module opsm_top_monitor #(
	parameter [10:0] SEG_DC_MASK = 11'h000
) (
	// bus
	input wire        hclk,
	input wire        hresetn,
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire [31:0] hwdata,
	input wire        hready,
	input wire [31:0] hrdata,
	input wire        hreadyout,
	input wire        hresp,
	// sources
	input wire        buzzer_one_shot_stop,
	input wire [10:0] seg_lcd_level,
	input wire        high_speed_osc_run,
	// pins
	input wire        inv_timer_or_carrier_pin_o,
	input wire        inv_timer_or_carrier_pin_oe,
	input wire        timer_clock_pin_o,
	input wire        timer_clock_pin_oe,
	input wire        osc_clock_pin_oe,
	input wire        buzzer_pin_o,
	input wire        buzzer_pin_oe,
	input wire        inv_buzzer_pin_o,
	input wire        inv_buzzer_pin_oe,
	input wire [10:0] segment_dc_pins_o,
	input wire [10:0] segment_dc_pins_oe
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ---------------------------------------------
	// shadow of data and hiz words, {seg, pins}
	// ---------------------------------------------
	logic        wr_r;
	logic [3:0]  off_r;
	logic [1:0]  age_r;
	logic [15:0] dat_r;
	logic [15:0] hiz_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_r  <= 1'b0;
			off_r <= 4'h0;
			age_r <= 2'h0;
			dat_r <= 16'h0000;
			hiz_r <= 16'h0000;
		end else begin
			wr_r  <= hsel & hready & htrans[1] & hwrite;
			off_r <= haddr[3:0];
			if (age_r != 2'h3)
				age_r <= age_r + 2'h1;
			if (wr_r && off_r == 4'h0)
				dat_r <= {hwdata[26:16], hwdata[4:0]};
			if (wr_r && off_r == 4'h4)
				hiz_r <= {hwdata[26:16], hwdata[4:0]};
		end
	end

	sequence rd_data;
		hsel && hready && htrans[1] && !hwrite && haddr[3:0] == 4'h0;
	endsequence
	sequence rd_hole;
		hsel && hready && htrans[1] && !hwrite && haddr[1:0] != 2'h0;
	endsequence

	// ---------------------------------------------
	// assertions
	// ---------------------------------------------
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("slave not ready or not okay");
	a_read_data: assert property (rd_data |=> {hrdata[26:16], hrdata[4:0]} == dat_r)
		else $error("data word read back wrong");
	a_hole_zero: assert property (rd_hole |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_osc_run_reset: assert property (age_r == 2'h1 |-> high_speed_osc_run)
		else $error("fast oscillator stopped after reset");
	a_timer_pair: assert property (inv_timer_or_carrier_pin_o |-> !timer_clock_pin_o)
		else $error("timer pin and inverse both high");
	a_buzz_pair: assert property (age_r != 2'h0 && !inv_buzzer_pin_o |-> buzzer_pin_o)
		else $error("buzzer pin and inverse both low");
	a_buzz_stop: assert property (buzzer_one_shot_stop [*3] |->
		inv_buzzer_pin_o && buzzer_pin_o == $past(dat_r[3]))
		else $error("stop does not idle buzzer pins");
	a_pin_oe: assert property (age_r[1] |-> {segment_dc_pins_oe, inv_buzzer_pin_oe,
		buzzer_pin_oe, osc_clock_pin_oe, timer_clock_pin_oe, inv_timer_or_carrier_pin_oe}
		== ~($past(hiz_r) & {SEG_DC_MASK, 5'h1f}))
		else $error("pin enable does not follow hiz");
	a_seg_level: assert property (age_r[1] |-> segment_dc_pins_o ==
		(($past(dat_r[15:5]) & SEG_DC_MASK) | ($past(seg_lcd_level) & ~SEG_DC_MASK)))
		else $error("segment pin level wrong");
endmodule

//--- bench/opsm_load.sv
// external loads on the sixteen output pins
// assumes no pull resistors: a floated pin wanders every cycle
`timescale 1ns/1ps

module opsm_load (
	// clock
	input  wire        hclk,
	// pins
	input  wire [15:0] pin_o,
	input  wire [15:0] pin_oe,
	output wire [15:0] pin_lvl
);
	logic [15:0] last = 16'h0000;
	// inverse of last level, so a floated pin never looks driven
	assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & ~last);
	always @(posedge hclk)
		last <= pin_lvl;
endmodule

//--- bench/testbench.sv
// self-checking bench of the output port block over ahb-lite
// assumes timer-clock and buzzer build options and eight dc segment pins
`timescale 1ns/1ps

module testbench;
	localparam [10:0] SEG_MASK = 11'h0ff;
	localparam [10:0] LCD_LVL  = 11'h5a5;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, timer_underflow;
	logic        low_osc, high_osc, buz_sig, buz_stop, hs_run;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	wire  [15:0] pin_o, pin_oe, pin_lvl;
	logic [7:0]  cyc = 8'h00;
	int          num_errors, checked, n, e;

	opsm_top #(.INV_TIMER_MODE(2'h1), .INV_BUZZER_MODE(1), .SEG_DC_MASK(SEG_MASK)) i_dut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .timer_underflow,
		.buzzer_signal(buz_sig), .ir_carrier_signal(1'b0), .low_speed_oscillator(low_osc),
		.high_speed_oscillator(high_osc), .buzzer_one_shot_stop(buz_stop),
		.seg_lcd_level(LCD_LVL), .high_speed_osc_run(hs_run),
		.inv_timer_or_carrier_pin_o(pin_o[0]), .inv_timer_or_carrier_pin_oe(pin_oe[0]),
		.timer_clock_pin_o(pin_o[1]), .timer_clock_pin_oe(pin_oe[1]),
		.osc_clock_pin_o(pin_o[2]), .osc_clock_pin_oe(pin_oe[2]),
		.buzzer_pin_o(pin_o[3]), .buzzer_pin_oe(pin_oe[3]),
		.inv_buzzer_pin_o(pin_o[4]), .inv_buzzer_pin_oe(pin_oe[4]),
		.segment_dc_pins_o(pin_o[15:5]), .segment_dc_pins_oe(pin_oe[15:5]));
	opsm_load i_load (.hclk, .pin_o, .pin_oe, .pin_lvl);

	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	// oscillators and buzzer waveform at fixed periods of 8, 4 and 16 cycles
	always @(posedge hclk) begin
		cyc      <= cyc + 8'h01;
		low_osc  <= cyc[2];
		high_osc <= cyc[1];
		buz_sig  <= cyc[3];
	end

	// ---------------------------------------------
	// bus and checking tasks
	// ---------------------------------------------
	task automatic ahb(input logic w, input logic [31:0] a, d);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic check(input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic settle;
		repeat (2) @(posedge hclk);
		#1;
	endtask
	// rising edges of one pin over 256 cycles, within one of e
	task automatic rises(input int i);
		logic p;
		p = pin_lvl[i];
		n = 0;
		repeat (256) begin
			@(posedge hclk);
			#1;
			if (pin_lvl[i] && !p)
				n++;
			p = pin_lvl[i];
		end
		check(32'(n >= e - 1 && n <= e + 1), 32'h1);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ---------------------------------------------
	// tests
	// ---------------------------------------------
	logic [31:0] ra [4] = '{32'h0, 32'h4, 32'h8, 32'h2};
	logic [31:0] rv [4] = '{32'h0, 32'h0, 32'h100, 32'h0};
	logic [31:0] bc [4] = '{32'h120, 32'h140, 32'h160, 32'h100};
	initial begin
		{hsel, hwrite, timer_underflow, buz_stop, htrans, haddr, hwdata} = '0;
		hresetn    = 1'b0;
		num_errors = 0;
		checked    = 0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		settle;
		check({pin_oe, pin_lvl[4:0]}, {16'hffff, 5'h10});
		for (int i = 0; i < 4; i++) begin
			ahb(1'b0, ra[i], 32'h0);
			check(rd, rv[i]);
		end
		// timer and osc data kept at 1, buzzer data at 0
		ahb(1'b1, 32'h0, 32'h03c3_0017);
		settle;
		check(pin_lvl, {11'h5c3, 5'h16});
		ahb(1'b1, 32'h4, 32'h07ff_001f);
		settle;
		check(pin_oe, {11'h700, 5'h00});
		ahb(1'b0, 32'h4, 32'h0);
		check(rd, 32'h07ff_001f);
		ahb(1'b1, 32'h0, 32'h003c_0017);
		ahb(1'b1, 32'h4, 32'h0);
		settle;
		check(pin_lvl, {11'h53c, 5'h16});
		ahb(1'b1, 32'h8, 32'h101);
		for (int k = 0; k < 4; k++) begin
			settle;
			check(pin_lvl[1:0], {k[0], ~k[0]});
			@(posedge hclk) timer_underflow <= 1'b1;
			@(posedge hclk) timer_underflow <= 1'b0;
		end
		// fast oscillator stays on while its ratios are selected
		for (int s = 0; s < 8; s++) begin
			ahb(1'b1, 32'h8, 32'h102 | (s << 2));
			repeat (16) @(posedge hclk);
			e = (s[2] ? 64 : 32) >> s[1:0];
			rises(2);
		end
		for (int i = 0; i < 4; i++) begin
			ahb(1'b1, 32'h8, bc[i]);
			buz_stop <= (i == 2);
			repeat (16) @(posedge hclk);
			e = (i < 2) ? 16 : 0;
			rises(3);
			rises(4);
			if (i > 1) begin
				check(pin_lvl[4:3], 2'b10);
				// status: timer clock low after four toggles, idle levels, all enables, stop
				ahb(1'b0, 32'hc, 32'h0);
				check(rd & 32'h0001_f1f9, (i == 2) ? 32'h0001_f168 : 32'h0001_f160);
			end
		end
		// reset again mid-run: registers return to reset values, pins drive again
		@(posedge hclk) hresetn <= 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		settle;
		check({pin_oe, pin_lvl[4:0]}, {16'hffff, 5'h10});
		for (int i = 0; i < 4; i++) begin
			ahb(1'b0, ra[i], 32'h0);
			check(rd, rv[i]);
		end
		tally_and_finish;
	end
	initial begin
		#(25 * 20000);
		num_errors++;
		tally_and_finish;
	end
endmodule

bind opsm_top opsm_top_monitor #(.SEG_DC_MASK(SEG_DC_MASK)) i_mon (
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
	.hreadyout, .hresp, .buzzer_one_shot_stop, .seg_lcd_level, .high_speed_osc_run,
	.inv_timer_or_carrier_pin_o, .inv_timer_or_carrier_pin_oe, .timer_clock_pin_o,
	.timer_clock_pin_oe, .osc_clock_pin_oe, .buzzer_pin_o, .buzzer_pin_oe,
	.inv_buzzer_pin_o, .inv_buzzer_pin_oe, .segment_dc_pins_o, .segment_dc_pins_oe);
